// File: emsw_ctrl.sv
// External memory select, overlay decode and wait state generator with Avalon-MM registers.
module emsw_ctrl #(
    parameter int PROG_DATA_W = 24,
    parameter int DATA_W      = 16
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [13:0]      ext_addr_o,
    output logic [23:0]      ext_wdata_o,
    input  wire logic [23:0] ext_rdata_i,
    output logic             ext_rd_n_o,
    output logic             ext_wr_n_o,
    output logic             prog_space_select_n_o,
    output logic             data_space_select_n_o,
    output logic             byte_space_select_n_o,
    output logic             io_space_select_n_o,
    output logic             combined_select_n_o
);
    logic [15:0]            wait_ctrl;
    logic [15:0]            overlay;
    logic [3:0]             combined_select_mask;
    logic [15:0]            sys_ctrl;
    logic [3:0]             req_word;
    logic [13:0]            req_offset;
    logic [23:0]            req_wdata;
    logic [23:0]            rdata_hold;
    logic                   refused;
    logic                   internal_hit;
    emsw_pkg::emsw_state_t  state;
    logic [3:0]             wait_cnt;
    logic [3:0]             sel_n;
    logic [23:0]            ext_rdata_s1;
    logic [23:0]            ext_rdata_s2;

    // Wait states from field N and mode bit.
    function automatic logic [3:0] wait_states(input logic [2:0] n, input logic mode);
        wait_states = mode ? {n, 1'b1} : {1'b0, n};
    endfunction

    wire logic [1:0]  req_space    = req_word[1:0];
    wire logic        req_wr       = req_word[emsw_pkg::REQ_WRITE_BIT];
    wire logic        host_mode    = req_word[emsw_pkg::REQ_HOST_BIT];
    wire logic        wmode        = wait_ctrl[emsw_pkg::WAIT_MODE_BIT];
    wire logic [3:0]  prog_ovl     = overlay[emsw_pkg::OVL_PROG_LSB +: 4];
    wire logic [3:0]  data_ovl     = overlay[emsw_pkg::OVL_DATA_LSB +: 4];
    wire logic        byte_enabled = !sys_ctrl[emsw_pkg::SYS_BYTE_DIS_BIT];
    wire logic        prog_ext_ovl = (req_offset >= emsw_pkg::PROG_OVL_BASE) &&
                                     (prog_ovl == emsw_pkg::OVL_EXT1 ||
                                      prog_ovl == emsw_pkg::OVL_EXT2);
    wire logic        data_ext_ovl = (req_offset <= emsw_pkg::DATA_OVL_TOP) &&
                                     (data_ovl == emsw_pkg::OVL_EXT1 ||
                                      data_ovl == emsw_pkg::OVL_EXT2);
    wire logic [1:0]  io_region    = req_offset[emsw_pkg::IO_REGION_LSB +: 2];
    wire logic [2:0]  io_field     = wait_ctrl[emsw_pkg::WAIT_IO0_LSB +
                                     io_region * emsw_pkg::WAIT_FIELD_W +: 3];
    wire logic [2:0]  data_field   = wait_ctrl[emsw_pkg::WAIT_DATA_LSB +: 3];
    wire logic [2:0]  prog_field   = sys_ctrl[emsw_pkg::SYS_PROG_WAIT_COUNT_LSB +: 3];
    wire logic        is_external  = (req_space == emsw_pkg::EMSW_SP_PROG) ? prog_ext_ovl :
                                     (req_space == emsw_pkg::EMSW_SP_DATA) ? data_ext_ovl :
                                     (req_space == emsw_pkg::EMSW_SP_BYTE) ? byte_enabled :
                                     1'b1;
    // Host mode cannot fetch from external program memory.
    wire logic        refuse_now   = host_mode && req_space == emsw_pkg::EMSW_SP_PROG &&
                                     prog_ext_ovl;
    wire logic [3:0]  next_waits   = (req_space == emsw_pkg::EMSW_SP_DATA) ?
                                     wait_states(data_field, wmode) :
                                     (req_space == emsw_pkg::EMSW_SP_IO) ?
                                     wait_states(io_field, wmode) :
                                     wait_states(prog_field, wmode);
    wire logic        ovl_bit13    = (req_space == emsw_pkg::EMSW_SP_PROG) ?
                                     (prog_ovl == emsw_pkg::OVL_EXT2) :
                                     (data_ovl == emsw_pkg::OVL_EXT2);
    wire logic [13:0] full_addr    = (req_space == emsw_pkg::EMSW_SP_IO) ?
                                     {3'h0, req_offset[emsw_pkg::IO_ADDR_W-1:0]} :
                                     (req_space == emsw_pkg::EMSW_SP_BYTE) ? req_offset :
                                     {ovl_bit13, req_offset[emsw_pkg::OFFSET_W-1:0]};
    wire logic [13:0] next_addr    = host_mode ? {13'h0, full_addr[0]} : full_addr;
    wire logic        data_width16 = (req_space != emsw_pkg::EMSW_SP_PROG) || host_mode;
    wire logic [23:0] next_wdata   = data_width16 ? {8'h00, req_wdata[DATA_W-1:0]} :
                                     req_wdata[PROG_DATA_W-1:0];
    wire logic        reg_area     = (req_space == emsw_pkg::EMSW_SP_DATA) &&
                                     (req_offset >= emsw_pkg::REG_AREA_BASE);
    wire logic        start_req    = avs_write_i && avs_address_i == emsw_pkg::ADDR_REQUEST &&
                                     state == emsw_pkg::EMSW_IDLE;
    wire logic        busy         = (state != emsw_pkg::EMSW_IDLE);
    wire logic [3:0]  sel_mask     = {combined_select_mask[emsw_pkg::MASK_IO_BIT],
                                      combined_select_mask[emsw_pkg::MASK_BYTE_BIT],
                                      combined_select_mask[emsw_pkg::MASK_DATA_BIT],
                                      combined_select_mask[emsw_pkg::MASK_PROG_BIT]};
    wire logic        wr_hit       = avs_write_i && !avs_waitrequest_o;
    wire logic [15:0] wr16         = avs_writedata_i[15:0];

    // A new request waits while an external access is still running.
    assign avs_waitrequest_o = (avs_address_i == emsw_pkg::ADDR_REQUEST) &&
                               (avs_read_i || avs_write_i) && busy && !start_req;

    always_comb begin
        case (avs_address_i)
            emsw_pkg::ADDR_WAIT_CTRL:   avs_readdata_o = {16'h0000, wait_ctrl};
            emsw_pkg::ADDR_OVERLAY:     avs_readdata_o = {16'h0000, overlay};
            emsw_pkg::ADDR_SELECT_MASK: avs_readdata_o = {28'h0000000, combined_select_mask};
            emsw_pkg::ADDR_SYS_CTRL:    avs_readdata_o = {16'h0000, sys_ctrl};
            emsw_pkg::ADDR_STATUS:      avs_readdata_o = {26'h0000000, refused, internal_hit,
                                                          sel_n};
            emsw_pkg::ADDR_REQUEST:     avs_readdata_o = {27'h0000000, busy, req_word};
            emsw_pkg::ADDR_OFFSET:      avs_readdata_o = {18'h00000, req_offset};
            emsw_pkg::ADDR_WDATA:       avs_readdata_o = {8'h00, req_wdata};
            emsw_pkg::ADDR_RDATA:       avs_readdata_o = {8'h00, rdata_hold};
            default:                    avs_readdata_o = 32'h00000000;
        endcase
    end

    // Stated defaults load on reset; reserved bits are masked off on write.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wait_ctrl            <= emsw_pkg::WAIT_CTRL_RESET;
            overlay              <= emsw_pkg::OVERLAY_RESET;
            combined_select_mask <= emsw_pkg::SELECT_MASK_RESET;
            sys_ctrl             <= emsw_pkg::SYS_CTRL_RESET;
            req_offset           <= 14'h0000;
            req_wdata            <= 24'h000000;
        end else if (wr_hit) begin
            case (avs_address_i)
                emsw_pkg::ADDR_WAIT_CTRL:   wait_ctrl <= wr16 & emsw_pkg::WAIT_CTRL_MASK;
                emsw_pkg::ADDR_OVERLAY:     overlay <= {8'h00, wr16[7:0]};
                emsw_pkg::ADDR_SELECT_MASK: combined_select_mask <= wr16[3:0];
                emsw_pkg::ADDR_SYS_CTRL:    sys_ctrl <= wr16 & emsw_pkg::SYS_CTRL_MASK;
                emsw_pkg::ADDR_OFFSET:      req_offset <= wr16[13:0];
                emsw_pkg::ADDR_WDATA:       req_wdata <= avs_writedata_i[23:0];
                default:                    req_offset <= req_offset;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        ext_rdata_s1 <= ext_rdata_i;
        ext_rdata_s2 <= ext_rdata_s1;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state        <= emsw_pkg::EMSW_IDLE;
            req_word     <= 4'h0;
            wait_cnt     <= 4'h0;
            sel_n        <= 4'hf;
            refused      <= 1'b0;
            internal_hit <= 1'b0;
            rdata_hold   <= 24'h000000;
            ext_addr_o   <= 14'h0000;
            ext_wdata_o  <= 24'h000000;
        end else begin
            case (state)
                emsw_pkg::EMSW_IDLE: begin
                    if (start_req) begin
                        req_word <= avs_writedata_i[3:0];
                        state    <= emsw_pkg::EMSW_DONE;
                    end
                end
                // A select spans the wait cycles, the cycle at wait count zero and one closing cycle.
                emsw_pkg::EMSW_DONE: begin
                    if (sel_n != 4'hf) begin
                        rdata_hold <= data_width16 ? {8'h00, ext_rdata_s2[15:0]} : ext_rdata_s2;
                        sel_n      <= 4'hf;
                        state      <= emsw_pkg::EMSW_IDLE;
                    end else begin
                        refused      <= refuse_now;
                        internal_hit <= !is_external || reg_area;
                        if (refuse_now || !is_external || reg_area) begin
                            state <= emsw_pkg::EMSW_IDLE;
                        end else begin
                            ext_addr_o  <= next_addr;
                            ext_wdata_o <= next_wdata;
                            wait_cnt    <= next_waits;
                            sel_n       <= ~(4'h1 << req_space);
                            state       <= emsw_pkg::EMSW_WAIT;
                        end
                    end
                end
                emsw_pkg::EMSW_WAIT: begin
                    if (wait_cnt == 4'h0) begin
                        state <= emsw_pkg::EMSW_DONE;
                    end else begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                end
                default: state <= emsw_pkg::EMSW_IDLE;
            endcase
        end
    end

    assign prog_space_select_n_o = sel_n[0];
    assign data_space_select_n_o = sel_n[1];
    assign byte_space_select_n_o = sel_n[2];
    assign io_space_select_n_o   = sel_n[3];
    // Combined select is a gate on the individual selects, so it shares their timing.
    assign combined_select_n_o   = ~|(~sel_n & sel_mask);
    assign ext_rd_n_o            = &sel_n | req_wr;
    assign ext_wr_n_o            = &sel_n | !req_wr;
endmodule

// File: emsw_pkg.sv
// Package with constants, register offsets and types of the external memory select block.
package emsw_pkg;
    localparam logic [3:0] ADDR_WAIT_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_OVERLAY     = 4'h1;
    localparam logic [3:0] ADDR_SELECT_MASK = 4'h2;
    localparam logic [3:0] ADDR_SYS_CTRL    = 4'h3;
    localparam logic [3:0] ADDR_STATUS      = 4'h4;
    localparam logic [3:0] ADDR_REQUEST     = 4'h5;
    localparam logic [3:0] ADDR_OFFSET      = 4'h6;
    localparam logic [3:0] ADDR_WDATA       = 4'h7;
    localparam logic [3:0] ADDR_RDATA       = 4'h8;
    // Wait state control word fields.
    localparam int WAIT_IO0_LSB  = 0;
    localparam int WAIT_DATA_LSB = 12;
    localparam int WAIT_MODE_BIT = 15;
    localparam int WAIT_FIELD_W  = 3;
    localparam logic [15:0] WAIT_CTRL_RESET = 16'hffff;
    localparam logic [15:0] WAIT_CTRL_MASK  = 16'hffff;
    // Overlay word fields: program selector in [3:0], data selector in [7:4].
    localparam int OVL_PROG_LSB = 0;
    localparam int OVL_DATA_LSB = 4;
    localparam logic [15:0] OVERLAY_RESET = 16'h0000;
    localparam logic [3:0] OVL_EXT1 = 4'h1;
    localparam logic [3:0] OVL_EXT2 = 4'h2;
    // Combined select mask: bit0 program, bit1 data, bit2 byte, bit3 I/O.
    localparam int MASK_PROG_BIT = 0;
    localparam int MASK_DATA_BIT = 1;
    localparam int MASK_BYTE_BIT = 2;
    localparam int MASK_IO_BIT   = 3;
    localparam logic [3:0] SELECT_MASK_RESET = 4'hb;
    // System control: bit3 disables the byte select, bits [2:0] program wait count.
    localparam int SYS_BYTE_DIS_BIT = 3;
    localparam int SYS_PROG_WAIT_COUNT_LSB    = 0;
    localparam logic [15:0] SYS_CTRL_RESET = 16'h0007;
    localparam logic [15:0] SYS_CTRL_MASK  = 16'h000f;
    // Access request word: bits [1:0] space, bit 2 write, bit 3 host mode.
    localparam int REQ_WRITE_BIT = 2;
    localparam int REQ_HOST_BIT  = 3;
    // Space boundaries.
    localparam logic [13:0] PROG_OVL_BASE  = 14'h2000;
    localparam logic [13:0] DATA_OVL_TOP   = 14'h1fff;
    localparam logic [13:0] REG_AREA_BASE  = 14'h3fe0;
    localparam int          REG_AREA_COUNT = 32;
    localparam int          IO_ADDR_W      = 11;
    localparam int          IO_REGION_LSB  = 9;
    localparam int          OFFSET_W       = 13;
    typedef enum logic [1:0] {
        EMSW_SP_PROG,
        EMSW_SP_DATA,
        EMSW_SP_BYTE,
        EMSW_SP_IO
    } emsw_space_t;
    typedef enum logic [1:0] {
        EMSW_IDLE,
        EMSW_WAIT,
        EMSW_DONE
    } emsw_state_t;
endpackage

// File: emsw_ctrl_asserts.sv
// Checker of select, strobe, address and handshake relations at the block ports.
module emsw_ctrl_asserts (
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_waitrequest_o,
    input wire logic [13:0] ext_addr_o,
    input wire logic        ext_rd_n_o,
    input wire logic        ext_wr_n_o,
    input wire logic        prog_space_select_n_o,
    input wire logic        data_space_select_n_o,
    input wire logic        byte_space_select_n_o,
    input wire logic        io_space_select_n_o,
    input wire logic        combined_select_n_o
);
    wire logic [3:0] sel_n = {io_space_select_n_o, byte_space_select_n_o,
                              data_space_select_n_o, prog_space_select_n_o};
    wire logic       act   = ~&sel_n;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_comb_idle; !act |-> combined_select_n_o; endproperty
    property p_comb_edge; $changed(combined_select_n_o) |-> $changed(act); endproperty
    property p_one_sel; $onehot0(~sel_n); endproperty
    property p_sel_min; $rose(act) |=> act; endproperty
    property p_sel_max; $rose(act) |-> ##[2:17] !act; endproperty
    property p_addr_hold; act && $past(act) |-> $stable(ext_addr_o); endproperty
    property p_io_top; !io_space_select_n_o |-> ext_addr_o[13:11] == 3'h0; endproperty
    property p_strobe; !(ext_rd_n_o && ext_wr_n_o) |-> act; endproperty
    property p_rw_excl; ext_rd_n_o || ext_wr_n_o; endproperty
    property p_wait_req; avs_waitrequest_o |-> avs_address_i == emsw_pkg::ADDR_REQUEST; endproperty
    a_comb_idle: assert property (p_comb_idle) else $error("combined select without select");
    a_comb_edge: assert property (p_comb_edge) else $error("combined select edge misplaced");
    a_one_sel: assert property (p_one_sel) else $error("two selects low together");
    a_sel_min: assert property (p_sel_min) else $error("select shorter than two cycles");
    a_sel_max: assert property (p_sel_max) else $error("select longer than seventeen cycles");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved during access");
    a_io_top: assert property (p_io_top) else $error("io access drives upper address");
    a_strobe: assert property (p_strobe) else $error("strobe without select");
    a_rw_excl: assert property (p_rw_excl) else $error("read and write strobes together");
    a_wait_req: assert property (p_wait_req) else $error("stall on other register");
    c_io: cover property ($rose(act) && !io_space_select_n_o);
    c_comb: cover property (!combined_select_n_o);
    c_stall: cover property (avs_waitrequest_o);
endmodule

bind emsw_ctrl emsw_ctrl_asserts u_chk (.*);

// File: emsw_ext_mem.sv
// External memory model answering the block's strobes on its far side.
module emsw_ext_mem (
    input  wire logic        mclk_i,
    input  wire logic [13:0] addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [3:0]  sel_n_i,
    output logic [23:0]      rdata_o
);
    logic [23:0] mem [16] = '{default: 24'h5a5a5a};
    logic [23:0] last = 24'h0;
    wire  logic  hit = ~&sel_n_i;
    // Released data lines toggle every cycle so a late capture cannot match.
    assign rdata_o = (hit && !rd_n_i) ? mem[addr_i[3:0]] : ~last;
    always @(posedge mclk_i) begin
        last <= rdata_o;
        if (hit && !wr_n_i) begin
            mem[addr_i[3:0]] <= wdata_i;
        end
    end
endmodule

// File: tb_emsw_ctrl.sv
// Self-checking bench of the external memory select block.
module tb_emsw_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] wc;
        logic [7:0]  ov;
        logic [3:0]  sc, mk, rq;
        logic [13:0] off, ea;
        int          lo;
    } emsw_row_t;
    logic        mclk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    wire  [3:0]  sel_n;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic [13:0] ext_addr_o, a;
    logic [23:0] ext_wdata_o, ext_rdata_i;
    logic        avs_waitrequest_o, ext_rd_n_o, ext_wr_n_o, combined_select_n_o;
    int          err_total = 0, checks_done = 0, cyc = 0, n, nc, stl;
    emsw_row_t rows[14] = '{
        '{16'h3000, 8'h10, 4'h0, 4'hb, 4'h1, 14'h0123, 14'h0123, 5},
        '{16'ha000, 8'h20, 4'h0, 4'h0, 4'h1, 14'h1fff, 14'h3fff, 7},
        '{16'h0000, 8'h01, 4'h1, 4'h1, 4'h0, 14'h2005, 14'h0005, 3},
        '{16'h8000, 8'h02, 4'h0, 4'hb, 4'h0, 14'h3fff, 14'h3fff, 3},
        '{16'h0688, 8'h00, 4'h0, 4'h8, 4'h3, 14'h01ff, 14'h01ff, 2},
        '{16'h0688, 8'h00, 4'h0, 4'h8, 4'h3, 14'h0200, 14'h0200, 3},
        '{16'h0688, 8'h00, 4'h0, 4'h8, 4'h3, 14'h05ff, 14'h05ff, 4},
        '{16'h0688, 8'h00, 4'h0, 4'h8, 4'h3, 14'h0600, 14'h0600, 5},
        '{16'h8e00, 8'h00, 4'h0, 4'h8, 4'h3, 14'h07ff, 14'h07ff, 17},
        '{16'h0000, 8'h00, 4'h0, 4'hb, 4'h1, 14'h0100, 14'h0000, 0},
        '{16'h0000, 8'h10, 4'h0, 4'hb, 4'h1, 14'h3fe0, 14'h0000, 0},
        '{16'h0000, 8'h01, 4'h0, 4'hb, 4'h0, 14'h1fff, 14'h0000, 0},
        '{16'h1000, 8'h10, 4'h0, 4'hb, 4'h9, 14'h1235, 14'h0001, 3},
        '{16'h0000, 8'h00, 4'h0, 4'hb, 4'hb, 14'h0603, 14'h0001, 2}};
    emsw_ctrl u_emsw_ctrl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .ext_addr_o(ext_addr_o), .ext_wdata_o(ext_wdata_o), .ext_rdata_i(ext_rdata_i),
        .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o), .prog_space_select_n_o(sel_n[0]),
        .data_space_select_n_o(sel_n[1]), .byte_space_select_n_o(sel_n[2]),
        .io_space_select_n_o(sel_n[3]), .combined_select_n_o(combined_select_n_o));
    emsw_ext_mem u_emsw_ext_mem (.mclk_i(mclk_i), .addr_i(ext_addr_o), .wdata_i(ext_wdata_o),
        .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .sel_n_i(sel_n), .rdata_o(ext_rdata_i));
    initial forever #5 mclk_i = ~mclk_i;
    task automatic print_verdict;
        if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        @(posedge mclk_i);
        avs_address_i <= ad;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        stl = 0;
        do begin
            @(posedge mclk_i);
            stl++;
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    // Software keeps reserved control bits at zero in every configuration write.
    task automatic cfg(input logic [15:0] wc, input logic [7:0] ov, input logic [3:0] sc, mk);
        bus(1'b1, emsw_pkg::ADDR_WAIT_CTRL, {16'h0, wc});
        bus(1'b1, emsw_pkg::ADDR_OVERLAY, {24'h0, ov});
        bus(1'b1, emsw_pkg::ADDR_SYS_CTRL, {28'h0, sc});
        bus(1'b1, emsw_pkg::ADDR_SELECT_MASK, {28'h0, mk});
    endtask
    // Issues one access and counts the cycles its own select and the combined select are low.
    task automatic run(input logic [13:0] off, input logic [3:0] rq);
        bus(1'b1, emsw_pkg::ADDR_OFFSET, {18'h0, off});
        bus(1'b1, emsw_pkg::ADDR_REQUEST, {28'h0, rq});
        n = 0;
        nc = 0;
        a = 14'h0;
        repeat (24) begin
            @(posedge mclk_i);
            if (sel_n[rq[1:0]] === 1'b0) begin
                n++;
                a = ext_addr_o;
            end
            if (combined_select_n_o === 1'b0) nc++;
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            cfg(rows[i].wc, rows[i].ov, rows[i].sc, rows[i].mk);
            run(rows[i].off, rows[i].rq);
            chk(32'(n), 32'(rows[i].lo));
            chk(32'(nc), rows[i].mk[rows[i].rq[1:0]] ? 32'(rows[i].lo) : 32'h0);
            chk({18'h0, a}, {18'h0, rows[i].ea});
        end
        cfg(16'h0000, 8'h01, 4'h0, 4'hb);
        run(14'h2001, 4'h8);
        chk(32'(n), 32'h0);
        bus(1'b0, emsw_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[5]), 32'h1);
        cfg(16'h3000, 8'h10, 4'h0, 4'hb);
        bus(1'b1, emsw_pkg::ADDR_WDATA, 32'h0000a5c3);
        run(14'h0004, 4'h5);
        bus(1'b1, emsw_pkg::ADDR_REQUEST, 32'h5);
        bus(1'b1, emsw_pkg::ADDR_REQUEST, 32'h1);
        chk(32'(stl > 1), 32'h1);
        repeat (24) @(posedge mclk_i);
        bus(1'b0, emsw_pkg::ADDR_RDATA, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h0000a5c3);
        cfg(16'h0000, 8'h01, 4'h1, 4'hb);
        bus(1'b1, emsw_pkg::ADDR_WDATA, 32'h00123456);
        run(14'h2004, 4'h4);
        run(14'h2004, 4'h0);
        chk(32'(n), 32'h3);
        bus(1'b0, emsw_pkg::ADDR_RDATA, 32'h0);
        chk(rd, 32'h00123456);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        chk({27'h0, combined_select_n_o, sel_n}, 32'h1f);
        bus(1'b0, emsw_pkg::ADDR_SELECT_MASK, 32'h0);
        chk({28'h0, rd[3:0]}, 32'hb);
        bus(1'b0, emsw_pkg::ADDR_SYS_CTRL, 32'h0);
        chk({16'h0, rd[15:0]}, {16'h0, emsw_pkg::SYS_CTRL_RESET});
        bus(1'b0, emsw_pkg::ADDR_WAIT_CTRL, 32'h0);
        chk({16'h0, rd[15:0]}, 32'hffff);
        bus(1'b0, 4'hf, 32'h0);
        run(14'h0010, 4'h2);
        chk(32'(n > 0), 32'h1);
        chk(32'(nc), 32'h0);
        bus(1'b1, emsw_pkg::ADDR_SELECT_MASK, 32'h4);
        run(14'h0010, 4'h2);
        chk(32'(nc), 32'(n));
        bus(1'b1, emsw_pkg::ADDR_SYS_CTRL, 32'h8);
        run(14'h0010, 4'h2);
        chk(32'(n), 32'h0);
        print_verdict();
    end
endmodule
